/* File: design/srq_pkg.sv */
package srq_pkg;

    // Register map
    localparam logic [5:0] ADDR_RATE      = 6'h04;
    localparam logic [5:0] ADDR_IRQ_DRIVE = 6'h05;
    localparam logic [7:0] RATE_RESET     = 8'h00;
    localparam logic [7:0] IRQ_RESET      = 8'h01;

    // Rate register fields
    localparam int RATE_SAMPLE_BIT = 0;
    localparam int RATE_DOUBLE_BIT = 1;
    localparam int RATE_WIDTH_BIT  = 2;
    localparam int RATE_FIELD_W    = 3;

    // Drive register field
    localparam int IRQ_FIELD_W = 2;

    // Chip code layout
    localparam int CODE_W      = 64;
    localparam int HALF_W      = 32;

    // Invalid low-three-bit patterns of the rate register
    localparam logic [2:0] RATE_BAD_A = 3'h1;
    localparam logic [2:0] RATE_BAD_B = 3'h2;
    localparam logic [2:0] RATE_BAD_C = 3'h3;
    localparam logic [2:0] RATE_BAD_D = 3'h7;

    // Data bits carried per code period
    localparam logic [1:0] BITS_ONE = 2'h1;
    localparam logic [1:0] BITS_TWO = 2'h2;

    // Interrupt pin drive styles
    localparam logic [1:0] DRV_CMOS_INV    = 2'h0;
    localparam logic [1:0] DRV_CMOS        = 2'h1;
    localparam logic [1:0] DRV_OPEN_DRAIN  = 2'h2;
    localparam logic [1:0] DRV_OPEN_SOURCE = 2'h3;

    // Effective baseband mode after gating
    typedef struct packed {
        logic code32;
        logic dbl_rate;
        logic os12;
    } srq_mode_t;

    // Register read or write request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } srq_req_t;

endpackage : srq_pkg

/* File: design/srq_rate_irq_cfg.sv */
`timescale 1ns/1ps

module srq_rate_irq_cfg (
    // Clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         nrst_i,
    // Register access
    input  wire srq_pkg::srq_req_t            reg_req_i,
    output logic [7:0]                        reg_rdata_o,
    output logic                              reg_rvalid_o,
    // Baseband inputs
    input  wire logic [srq_pkg::CODE_W-1:0]   chip_code_i,
    input  wire logic                         code_half_sel_i,
    input  wire logic                         irq_req_i,
    // Baseband mode outputs
    output srq_pkg::srq_mode_t                mode_o,
    output logic [1:0]                        bits_per_code_o,
    output logic                              rate_invalid_o,
    output logic [srq_pkg::HALF_W-1:0]        code_a_o,
    output logic [srq_pkg::HALF_W-1:0]        code_b_o,
    output logic [srq_pkg::CODE_W-1:0]        code_full_o,
    // Interrupt pin
    output logic                              irq_o,
    output logic                              irq_oe_o
);

    logic [srq_pkg::RATE_FIELD_W-1:0] rate_r;
    logic [srq_pkg::IRQ_FIELD_W-1:0]  drive_r;
    logic [7:0]                       rdata_r;
    logic                             rvalid_r;
    srq_pkg::srq_mode_t               mode_r;
    srq_pkg::srq_mode_t               mode_nxt;
    logic [1:0]                       bits_r;
    logic                             invalid_r;
    logic [srq_pkg::HALF_W-1:0]       code_a_r;
    logic [srq_pkg::HALF_W-1:0]       code_b_r;
    logic [srq_pkg::CODE_W-1:0]       code_full_r;
    logic                             irq_r;
    logic                             irq_oe_r;

    function automatic logic [srq_pkg::HALF_W-1:0] code_half(
        input logic [srq_pkg::CODE_W-1:0] code,
        input logic                       upper
    );
        code_half = upper ? code[srq_pkg::CODE_W-1:srq_pkg::HALF_W] : code[srq_pkg::HALF_W-1:0];
    endfunction : code_half

    // Only the defined bits are stored, so reserved bits always read back zero
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            rate_r  <= srq_pkg::RATE_RESET[srq_pkg::RATE_FIELD_W-1:0];
            drive_r <= srq_pkg::IRQ_RESET[srq_pkg::IRQ_FIELD_W-1:0];
        end
        else if (reg_req_i.wr)
        begin
            if (reg_req_i.addr == srq_pkg::ADDR_RATE)
                rate_r <= reg_req_i.wdata[srq_pkg::RATE_FIELD_W-1:0];
            if (reg_req_i.addr == srq_pkg::ADDR_IRQ_DRIVE)
                drive_r <= reg_req_i.wdata[srq_pkg::IRQ_FIELD_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= reg_req_i.rd;
            if (!reg_req_i.rd)
                rdata_r <= 8'h00;
            else if (reg_req_i.addr == srq_pkg::ADDR_RATE)
                rdata_r <= {5'h00, rate_r};
            else if (reg_req_i.addr == srq_pkg::ADDR_IRQ_DRIVE)
                rdata_r <= {6'h00, drive_r};
            else
                rdata_r <= 8'h00;
        end
    end

    always_comb
    begin
        mode_nxt.code32   = rate_r[srq_pkg::RATE_WIDTH_BIT];
        mode_nxt.dbl_rate = rate_r[srq_pkg::RATE_DOUBLE_BIT] & rate_r[srq_pkg::RATE_WIDTH_BIT];
        mode_nxt.os12     = rate_r[srq_pkg::RATE_SAMPLE_BIT] & rate_r[srq_pkg::RATE_WIDTH_BIT]
                            & ~rate_r[srq_pkg::RATE_DOUBLE_BIT];
    end

    // Invalid patterns are flagged, not corrected; the gating above keeps them harmless
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            mode_r    <= '0;
            bits_r    <= srq_pkg::BITS_ONE;
            invalid_r <= 1'b0;
        end
        else
        begin
            mode_r    <= mode_nxt;
            // two bits per period / one bit
            bits_r    <= mode_nxt.dbl_rate ? srq_pkg::BITS_TWO : srq_pkg::BITS_ONE;
            invalid_r <= (rate_r == srq_pkg::RATE_BAD_A) || (rate_r == srq_pkg::RATE_BAD_B)
                         || (rate_r == srq_pkg::RATE_BAD_C) || (rate_r == srq_pkg::RATE_BAD_D);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            code_a_r    <= '0;
            code_b_r    <= '0;
            code_full_r <= '0;
        end
        else
        begin
            code_full_r <= chip_code_i;
            if (mode_nxt.dbl_rate)
            begin
                code_a_r <= code_half(chip_code_i, 1'b0);
                code_b_r <= code_half(chip_code_i, 1'b1);
            end
            else if (mode_nxt.code32)
            begin
                // half select / second correlator on other half
                code_a_r <= code_half(chip_code_i, code_half_sel_i);
                code_b_r <= code_half(chip_code_i, ~code_half_sel_i);
            end
            else
            begin
                code_a_r <= '0;
                code_b_r <= '0;
            end
        end
    end

    // Drive style sampled each cycle, so a change in drive code applies on the next edge
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            // Matches the reset drive code: push-pull, deasserted low
            irq_r    <= 1'b0;
            irq_oe_r <= 1'b1;
        end
        else
        begin
            case (drive_r)
                srq_pkg::DRV_OPEN_SOURCE:
                begin
                    irq_r    <= 1'b1;
                    irq_oe_r <= irq_req_i;
                end
                srq_pkg::DRV_OPEN_DRAIN:
                begin
                    irq_r    <= 1'b0;
                    irq_oe_r <= irq_req_i;
                end
                srq_pkg::DRV_CMOS:
                begin
                    irq_r    <= irq_req_i;
                    irq_oe_r <= 1'b1;
                end
                default:
                begin
                    irq_r    <= ~irq_req_i;
                    irq_oe_r <= 1'b1;
                end
            endcase
        end
    end

    assign reg_rdata_o     = rdata_r;
    assign reg_rvalid_o    = rvalid_r;
    assign mode_o          = mode_r;
    assign bits_per_code_o = bits_r;
    assign rate_invalid_o  = invalid_r;
    assign code_a_o        = code_a_r;
    assign code_b_o        = code_b_r;
    assign code_full_o     = code_full_r;
    assign irq_o           = irq_r;
    assign irq_oe_o        = irq_oe_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_rate_write;
        reg_req_i.wr && reg_req_i.addr == srq_pkg::ADDR_RATE;
    endsequence

    sequence s_rate_read;
        reg_req_i.rd && reg_req_i.addr == srq_pkg::ADDR_RATE && !reg_req_i.wr;
    endsequence

    chk_code_width_follow: assert property (
        s_rate_write ##1 !reg_req_i.wr [*1] ##1 1'b1
            |-> mode_o.code32 == $past(reg_req_i.wdata[srq_pkg::RATE_WIDTH_BIT], 2))
        else $error("code width mode does not follow written bit");

    chk_double_rate_gate: assert property (
        mode_o.dbl_rate |-> mode_o.code32)
        else $error("double rate active with 64-chip codes");

    chk_bits_per_period: assert property (
        mode_o.dbl_rate |-> bits_per_code_o == srq_pkg::BITS_TWO)
        else $error("double rate does not carry two bits per code");

    chk_normal_one_bit: assert property (
        !mode_o.dbl_rate |-> bits_per_code_o == srq_pkg::BITS_ONE)
        else $error("normal rate does not carry one bit per code");

    chk_oversample_gate: assert property (
        mode_o.os12 |-> mode_o.code32 && !mode_o.dbl_rate)
        else $error("12x oversampling outside 32-chip normal rate");

    chk_double_halves: assert property (
        ##1 $past(mode_nxt.dbl_rate) |-> code_a_o == $past(chip_code_i[31:0])
                                     && code_b_o == $past(chip_code_i[63:32]))
        else $error("double rate halves not taken from the full code");

    chk_half_select: assert property (
        ##1 $past(mode_nxt.code32 && !mode_nxt.dbl_rate && code_half_sel_i)
            |-> code_a_o == $past(chip_code_i[63:32]) && code_b_o == $past(chip_code_i[31:0]))
        else $error("upper half not selected");

    chk_reserved_read: assert property (
        s_rate_read |=> reg_rvalid_o && reg_rdata_o[7:3] == 5'h00)
        else $error("reserved rate bits read nonzero");

    chk_open_source: assert property (
        drive_r == srq_pkg::DRV_OPEN_SOURCE && $stable(drive_r) [*2]
            |-> irq_o && irq_oe_o == $past(irq_req_i))
        else $error("open source drive wrong");

    chk_cmos_inverted: assert property (
        drive_r == srq_pkg::DRV_CMOS_INV && $stable(drive_r) [*2]
            |-> irq_oe_o && irq_o == !$past(irq_req_i))
        else $error("inverted push-pull drive wrong");

    chk_float_enable: assert property (
        !irq_oe_o |-> $past(drive_r[1]) && !$past(irq_req_i))
        else $error("pin floats outside open drive idle");

    sequence s_drive_write;
        reg_req_i.wr && reg_req_i.addr == srq_pkg::ADDR_IRQ_DRIVE;
    endsequence

    chk_open_drain: assert property (
        drive_r == srq_pkg::DRV_OPEN_DRAIN && $stable(drive_r) [*2]
            |-> !irq_o && irq_oe_o == $past(irq_req_i))
        else $error("open drain drive wrong");

    chk_cmos_true: assert property (
        drive_r == srq_pkg::DRV_CMOS && $stable(drive_r) [*2]
            |-> irq_oe_o && irq_o == $past(irq_req_i))
        else $error("push-pull drive wrong");

    chk_half_lower: assert property (
        ##1 $past(mode_nxt.code32 && !mode_nxt.dbl_rate && !code_half_sel_i)
            |-> code_a_o == $past(chip_code_i[31:0]) && code_b_o == $past(chip_code_i[63:32]))
        else $error("lower half not selected");

    chk_wide_code_idle: assert property (
        ##1 !$past(mode_nxt.code32) |-> code_a_o == '0 && code_b_o == '0)
        else $error("half codes active with 64-chip codes");

    chk_full_code_copy: assert property (
        1'b1 |=> code_full_o == $past(chip_code_i))
        else $error("full code not copied");

    chk_drive_store: assert property (
        s_drive_write |=> drive_r == $past(reg_req_i.wdata[srq_pkg::IRQ_FIELD_W-1:0]))
        else $error("drive code not stored");

    chk_push_pull_drives: assert property (
        !drive_r[1] |=> irq_oe_o)
        else $error("push-pull pin not driven");

endmodule : srq_rate_irq_cfg

/* File: test/srq_host_model.sv */
`timescale 1ns/1ps
module srq_host_model (
    // Clock
    input  wire logic         ref_clk_i,
    // Register port
    output srq_pkg::srq_req_t req_o,
    input  wire logic [7:0]   rdata_i,
    input  wire logic         rvalid_i
);
    initial req_o = '0;

    // Strobe lasts one cycle; the answer is taken just after the edge that takes it
    task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                          input logic bad_ok, output logic [7:0] rdata, output logic rvalid);
        logic [7:0] data;
        data = wdata & ((addr == srq_pkg::ADDR_RATE) ? 8'h07 : 8'h03);
        if (!bad_ok && addr == srq_pkg::ADDR_RATE
            && (data[2:0] == srq_pkg::RATE_BAD_A || data[2:0] == srq_pkg::RATE_BAD_B
                || data[2:0] == srq_pkg::RATE_BAD_C || data[2:0] == srq_pkg::RATE_BAD_D))
            data = 8'h00;
        @(posedge ref_clk_i);
        #1;
        req_o = {wr, ~wr, addr, data};
        @(posedge ref_clk_i);
        #1;
        req_o  = '0;
        rdata  = rdata_i;
        rvalid = rvalid_i;
    endtask : access
endmodule : srq_host_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e, m) \
    begin \
        checked++; \
        if ((a) !== (e)) \
        begin \
            mismatches++; \
            $display("wrong value at %0t ns: %s", $time, m); \
        end \
    end
module tb_top;
    logic               ref_clk_i;
    logic               nrst_i;
    logic               code_half_sel_i;
    logic               irq_req_i;
    logic               reg_rvalid_o;
    logic               rate_invalid_o;
    logic               irq_o;
    logic               irq_oe_o;
    logic               rv;
    logic [7:0]         reg_rdata_o;
    logic [7:0]         rd;
    logic [1:0]         bits_per_code_o;
    logic [63:0]        chip_code_i;
    logic [63:0]        code_full_o;
    logic [31:0]        code_a_o;
    logic [31:0]        code_b_o;
    logic [2:0]         good_rates [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
    srq_pkg::srq_req_t  reg_req_i;
    srq_pkg::srq_mode_t mode_o;
    int                 mismatches = 0;
    int                 checked = 0;
    integer             seed = 32;

    srq_host_model host (.ref_clk_i(ref_clk_i), .req_o(reg_req_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));

    srq_rate_irq_cfg uut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .chip_code_i(chip_code_i), .code_half_sel_i(code_half_sel_i),
        .irq_req_i(irq_req_i), .mode_o(mode_o), .bits_per_code_o(bits_per_code_o),
        .rate_invalid_o(rate_invalid_o), .code_a_o(code_a_o), .code_b_o(code_b_o),
        .code_full_o(code_full_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Rate patterns that the host must never program
    function automatic logic exp_invalid(input logic [2:0] rate);
        exp_invalid = (rate == srq_pkg::RATE_BAD_A) || (rate == srq_pkg::RATE_BAD_B)
                      || (rate == srq_pkg::RATE_BAD_C) || (rate == srq_pkg::RATE_BAD_D);
    endfunction : exp_invalid

    // Correlator code: zero with 64-chip codes, lower half first at double rate
    function automatic logic [31:0] exp_half(input logic [2:0] rate, input logic [63:0] code,
                                             input logic sel, input logic second);
        logic upper;
        upper    = (rate[1] | !sel) ? second : !second;
        exp_half = !rate[2] ? 32'h0 : (upper ? code[63:32] : code[31:0]);
    endfunction : exp_half

    task automatic reset_check();
        host.access(1'b0, srq_pkg::ADDR_RATE, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, srq_pkg::RATE_RESET}, "rate reset value")
        host.access(1'b0, srq_pkg::ADDR_IRQ_DRIVE, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, srq_pkg::IRQ_RESET}, "drive reset value")
        `CHK({mode_o, bits_per_code_o}, {3'h0, srq_pkg::BITS_ONE}, "mode after reset")
        `CHK({irq_oe_o, irq_o}, {1'b1, irq_req_i}, "pin after reset")
        $display("test reset done");
    endtask : reset_check

    task automatic run_case(input logic [2:0] rate, input logic [1:0] drv, input logic [63:0] code,
                            input logic sel, input logic req, input logic bad_ok, input logic [4:0] junk);
        logic [31:0] ea;
        logic [31:0] eb;
        chip_code_i     = code;
        code_half_sel_i = sel;
        irq_req_i       = req;
        host.access(1'b1, srq_pkg::ADDR_RATE, {junk, rate}, bad_ok, rd, rv);
        host.access(1'b1, srq_pkg::ADDR_IRQ_DRIVE, {junk, 1'b0, drv}, 1'b0, rd, rv);
        repeat (3) @(posedge ref_clk_i);
        #1;
        ea = exp_half(rate, code, sel, 1'b0);
        eb = exp_half(rate, code, sel, 1'b1);
        `CHK(mode_o.code32, rate[2], "code width")
        `CHK(mode_o.dbl_rate, rate[2] & rate[1], "double rate")
        `CHK(bits_per_code_o, (rate[2] & rate[1]) ? srq_pkg::BITS_TWO : srq_pkg::BITS_ONE, "bits")
        `CHK(mode_o.os12, rate[2] & ~rate[1] & rate[0], "oversampling")
        `CHK(rate_invalid_o, exp_invalid(rate), "invalid flag")
        `CHK(code_a_o, ea, "first code")
        `CHK(code_b_o, eb, "second code")
        `CHK(code_full_o, code, "full code")
        `CHK(irq_oe_o, drv[1] ? req : 1'b1, "pin enable")
        if (drv[1] && req)
            `CHK(irq_o, drv[0], "open pin level")
        if (!drv[1])
            `CHK(irq_o, ~(drv[0] ^ req), "push-pull level")
        host.access(1'b0, srq_pkg::ADDR_RATE, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, 5'h00, rate}, "rate readback")
        host.access(1'b0, srq_pkg::ADDR_IRQ_DRIVE, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, 6'h00, drv}, "drive readback")
    endtask : run_case

    initial
    begin
        nrst_i          = 1'b0;
        chip_code_i     = 64'h0;
        code_half_sel_i = 1'b0;
        irq_req_i       = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        reset_check();
        // Every rate pattern, invalid ones included, against every drive code
        for (int i = 0; i < 32; i++)
            run_case(i[2:0], i[4:3], {$random(seed), $random(seed)}, i[0], i[1], 1'b1, 5'h00);
        $display("test corners done");
        for (int i = 0; i < 40; i++)
            run_case(good_rates[$unsigned($random(seed)) % 4], 2'($random(seed)), {$random(seed), $random(seed)},
                     1'($random(seed)), 1'($random(seed)), 1'b0, 5'($random(seed)));
        $display("test random done");
        // Known contents first, so a stray decode of the unmapped write shows up
        run_case(3'h5, 2'h2, 64'h0123_4567_89AB_CDEF, 1'b1, 1'b1, 1'b0, 5'h1F);
        host.access(1'b1, 6'h06, 8'hFF, 1'b0, rd, rv);
        host.access(1'b0, 6'h06, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, 8'h00}, "unmapped read")
        host.access(1'b0, srq_pkg::ADDR_RATE, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, 8'h05}, "rate kept after unmapped write")
        host.access(1'b0, srq_pkg::ADDR_IRQ_DRIVE, 8'h00, 1'b0, rd, rv);
        `CHK({rv, rd}, {1'b1, 8'h02}, "drive kept after unmapped write")
        $display("test unmapped done");
        @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        reset_check();
        final_report();
    end

    initial
    begin
        #400000;
        mismatches++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        final_report();
    end
endmodule : tb_top
